// >>> hw/binary_io_latch_ack_logic.sv
// Binary I/O: input debounce, relay outputs with latch/ack/hold, latched LEDs, health LED
//
// Contract
// R1 - Relay drives OR of seven selected triggers
// R2 - Per-slot inversion; unassigned slot gives zero
// R3 - Collective inversion of combined output state
// R4 - No slot assigned: state zero, no inversion
// R5 - Mode selects working or closed-circuit current
// R6 - Unlatched relay follows combined trigger state
// R7 - Latched relay holds until acknowledged
// R8 - Latch clears only when triggers idle plus ack
// R9 - Own ack signal only when latched, triggers idle
// R10 - Ack refused until off-delay time expires
// R11 - Relay holds each state minimum hold time
// R12 - Latched states survive warm and cold restart; this block keeps them through reset only
// R13 - Group output ack needs remote reset active
// R14 - Input change accepted at once, then debounced
// R15 - Optional inversion of each debounced input
// R16 - LED cleared by panel, own, global, SCADA, alarm
// R17 - Group LED clear needs remote reset active
// R18 - Alarm clears only ack-by-alarm LEDs
// R19 - Health LED flashes during boot, steady after
// R20 - Latched LED clears only with triggers idle
// R21 - Times are counters loaded from configuration
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "bio_defs.svh"
module binary_io_latch_ack_logic (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`N_DI-1:0] di_raw,
  input wire logic [`N_SIG-1:0] trig_in,
  input wire logic all_output_clear_source,
  input wire logic all_indicator_clear_source,
  input wire logic prot_alarm,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [`N_OUT-1:0] relay_drive,
  output logic [`N_LED-1:0] led_on,
  output logic [`N_DI-1:0] di_state,
  output logic health_led
);
  import bio_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    axs_t wst;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] gen_cfg;
    logic [`N_DI-1:0] di_inv;
    logic [15:0] deb_ms;
    logic [31:0] boot_div;
    logic [`N_OUT*8-1:0][31:0] ocfg;
    logic [`N_LED*8-1:0][31:0] lcfg;
    logic [`N_DI-1:0] di_deb;
    logic [`N_DI-1:0][31:0] di_cnt;
    logic [`N_DI-1:0] di_out;
    logic [`N_OUT-1:0] o_latch;
    logic [`N_OUT-1:0] o_state;
    logic [`N_OUT-1:0][31:0] o_hold;
    logic [`N_OUT-1:0][31:0] o_toff;
    logic [`N_OUT-1:0] relay;
    logic [`N_LED-1:0] l_latch;
    logic [`N_LED-1:0] led;
    logic [3:0] cmd;
    logic [31:0] boot_cnt;
    logic health;
  } state_t;

  state_t q;
  state_t d;

  // ****************************************
  // Combinational helpers
  // ****************************************
  logic [`N_OUT-1:0] o_comb;
  logic [`N_OUT-1:0] o_any;
  logic [`N_LED-1:0] l_comb;
  logic [`N_LED-1:0] l_any;
  logic [`N_SIG-1:0] sigs;

  // Debounced inputs are selectable as triggers in the upper eight positions
  assign sigs = {q.di_out, trig_in[`N_SIG-`N_DI-1:0]};

  genvar gi;
  genvar gs;
  generate
    for (gi = 0; gi < `N_OUT; gi++) begin : g_out
      logic [`N_SLOT-1:0] v;
      logic [`N_SLOT-1:0] a;
      for (gs = 0; gs < `N_SLOT; gs++) begin : g_slot
        logic [31:0] c;
        assign c = q.ocfg[gi*8+gs];
        assign a[gs] = c[`F_ASSIGNED];
        assign v[gs] = c[`F_ASSIGNED] & // R2
          (sigs[c[`F_SEL_HI:`F_SEL_LO]] ^ c[`F_SLOT_INV]);
      end
      assign o_any[gi] = |a;
      // R1 R3 R4
      assign o_comb[gi] = o_any[gi] & ((|v) ^ q.ocfg[gi*8+7][`F_COLL_INV]);
    end
    for (gi = 0; gi < `N_LED; gi++) begin : g_led
      logic [4:0] v;
      logic [4:0] a;
      for (gs = 0; gs < 5; gs++) begin : g_slot
        logic [31:0] c;
        assign c = q.lcfg[gi*8+gs];
        assign a[gs] = c[`F_ASSIGNED];
        assign v[gs] = c[`F_ASSIGNED] & (sigs[c[`F_SEL_HI:`F_SEL_LO]] ^ c[`F_SLOT_INV]);
      end
      assign l_any[gi] = |a;
      assign l_comb[gi] = |v;
    end
  endgenerate

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic wr;
    logic [9:0] widx;
    logic [9:0] ridx;
    logic [31:0] m;
    logic [31:0] cfg;
    logic grp_out;
    logic grp_led;
    logic ack;
    logic want;
    wr = 1'b0;
    widx = 10'h000;
    ridx = 10'h000;
    m = 32'h00000000;
    cfg = 32'h00000000;
    grp_out = 1'b0;
    grp_led = 1'b0;
    ack = 1'b0;
    want = 1'b0;
    d = q;
    d.cmd = 4'h0;

    // AXI write: address and data taken in either order, response after both
    d.awready = 1'b0;
    d.wready = 1'b0;
    if (s_axi_awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    unique case (q.wst)
      ax_idle: begin
        d.awready = !d.aw_got && !(s_axi_awvalid && q.awready);
        d.wready = !d.w_got && !(s_axi_wvalid && q.wready);
        if (q.aw_got && q.w_got) begin
          wr = 1'b1;
          d.bvalid = 1'b1;
          d.bresp = 2'b00;
          d.wst = ax_resp;
          d.awready = 1'b0;
          d.wready = 1'b0;
        end
      end
      ax_resp: begin
        if (s_axi_bready) begin
          d.bvalid = 1'b0;
          d.aw_got = 1'b0;
          d.w_got = 1'b0;
          d.wst = ax_idle;
          d.awready = 1'b1;
          d.wready = 1'b1;
        end
      end
    endcase
    if (wr) begin
      for (int b = 0; b < 4; b++) begin
        if (q.wstrb[b]) begin
          m[b*8 +: 8] = 8'hFF;
        end
      end
      widx = q.awaddr[11:2];
      unique case (q.awaddr)
        `A_GLOBAL: begin
          d.gen_cfg = ((q.gen_cfg & ~m) | (q.wdata & m)) & 32'h00000003;
          d.cmd = q.wdata[`F_CMD_SCADA_LED:`F_CMD_PANEL_OUT] & {4{q.wstrb[1]}};
        end
        `A_DI_INV: d.di_inv = (q.di_inv & ~m[7:0]) | (q.wdata[7:0] & m[7:0]);
        `A_DEB: d.deb_ms = (q.deb_ms & ~m[15:0]) | (q.wdata[15:0] & m[15:0]);
        `A_BOOT_DIV: d.boot_div = (q.boot_div & ~m) | (q.wdata & m);
        default: begin
          // Each table is 32 words on a 128-byte boundary, so word bits 4:0 index it
          if ((q.awaddr & 12'hF80) == `A_OUT_BASE) begin
            d.ocfg[widx[4:0]] = (q.ocfg[widx[4:0]] & ~m) | (q.wdata & m);
          end else if ((q.awaddr & 12'hF80) == `A_LED_BASE) begin
            d.lcfg[widx[4:0]] = (q.lcfg[widx[4:0]] & ~m) | (q.wdata & m);
          end else begin
            d.bresp = 2'b10;
          end
        end
      endcase
    end

    // AXI read
    d.arready = 1'b0;
    if (q.rvalid) begin
      if (s_axi_rready) begin
        d.rvalid = 1'b0;
      end
    end else if (s_axi_arvalid && !q.arready) begin
      d.arready = 1'b1;
    end else if (s_axi_arvalid && q.arready) begin
      ridx = s_axi_araddr[11:2];
      d.rvalid = 1'b1;
      d.rresp = 2'b00;
      unique case (s_axi_araddr)
        `A_GLOBAL: d.rdata = q.gen_cfg;
        `A_STATUS: d.rdata = {8'h00, q.di_out, q.led, q.l_latch, q.relay, q.o_latch};
        `A_DI_INV: d.rdata = {24'h000000, q.di_inv};
        `A_DEB: d.rdata = {16'h0000, q.deb_ms};
        `A_BOOT_DIV: d.rdata = q.boot_div;
        default: begin
          if ((s_axi_araddr & 12'hF80) == `A_OUT_BASE) begin
            d.rdata = q.ocfg[ridx[4:0]];
          end else if ((s_axi_araddr & 12'hF80) == `A_LED_BASE) begin
            d.rdata = q.lcfg[ridx[4:0]];
          end else begin
            d.rdata = 32'h00000000;
            d.rresp = 2'b10;
          end
        end
      endcase
    end

    // Digital inputs
    for (int i = 0; i < `N_DI; i++) begin
      if (q.di_cnt[i] != 32'h00000000) begin
        d.di_cnt[i] = q.di_cnt[i] - 32'h00000001; // R14
      end else if (di_raw[i] != q.di_deb[i]) begin
        d.di_deb[i] = di_raw[i]; // R14
        d.di_cnt[i] = 32'(q.deb_ms) * 32'(`MS_CYC); // R21
      end
      d.di_out[i] = q.di_deb[i] ^ q.di_inv[i]; // R15
    end

    // Relay outputs
    grp_out = q.gen_cfg[`F_REMOTE_RESET] & // R13
      (all_output_clear_source | q.cmd[1]);
    for (int i = 0; i < `N_OUT; i++) begin
      cfg = q.ocfg[i*8+7];
      if (q.o_toff[i] != 32'h00000000) begin
        d.o_toff[i] = q.o_toff[i] - 32'h00000001;
      end
      if (o_comb[i]) begin
        d.o_toff[i] = 32'(cfg[`F_TOFF_HI:`F_TOFF_LO]) * 32'(`MS_CYC); // R10 R21
      end
      ack = q.cmd[0] | grp_out |
        (cfg[`F_LATCH] & cfg[`F_ACK_EN] & sigs[cfg[`F_ACK_SEL_HI:`F_ACK_SEL_LO]]); // R9
      if (!cfg[`F_LATCH] || !o_any[i]) begin
        d.o_latch[i] = 1'b0; // R8
      end else if (o_comb[i]) begin
        d.o_latch[i] = 1'b1; // R7
      end else if (ack && q.o_toff[i] == 32'h00000000) begin
        d.o_latch[i] = 1'b0; // R8 R10
      end
      want = cfg[`F_LATCH] ? (o_comb[i] | q.o_latch[i]) : o_comb[i]; // R6 R7
      if (q.o_hold[i] != 32'h00000000) begin
        d.o_hold[i] = q.o_hold[i] - 32'h00000001;
      end else begin
        // Taking want unconditionally lets a never-reset state settle on first use
        d.o_state[i] = want; // R11
        if (want != q.o_state[i]) begin
          d.o_hold[i] = 32'(cfg[`F_THOLD_HI:`F_THOLD_LO]) * 32'(`MS_CYC); // R11 R21
        end
      end
      // Closed-circuit keeps the coil energised at rest so a broken wire trips
      d.relay[i] = q.o_state[i] ^ cfg[`F_CLOSED]; // R5
    end

    // LEDs
    grp_led = q.gen_cfg[`F_REMOTE_RESET] & (all_indicator_clear_source | q.cmd[3]); // R17
    for (int i = 0; i < `N_LED; i++) begin
      cfg = q.lcfg[i*8+7];
      ack = q.cmd[2] | grp_led |
        (cfg[`F_LED_BY_ALARM] & prot_alarm) | // R16 R18
        (cfg[`F_ACK_EN] & sigs[cfg[`F_ACK_SEL_HI:`F_ACK_SEL_LO]]);
      if (!cfg[`F_LED_LATCH] || !l_any[i]) begin
        d.l_latch[i] = 1'b0;
      end else if (l_comb[i]) begin
        d.l_latch[i] = 1'b1;
      end else if (ack) begin
        d.l_latch[i] = 1'b0; // R20
      end
      d.led[i] = l_comb[i] | (cfg[`F_LED_LATCH] & q.l_latch[i]); // R20
    end

    // Health LED
    if (q.gen_cfg[`F_BOOT_DONE]) begin
      d.health = 1'b1; // R19
      d.boot_cnt = 32'h00000000;
    end else if (q.boot_cnt >= q.boot_div) begin
      d.boot_cnt = 32'h00000000;
      d.health = !q.health; // R19
    end else begin
      d.boot_cnt = q.boot_cnt + 32'h00000001;
    end
  end

  // ****************************************
  // Register
  // ****************************************
  // Latch and relay state are left out of reset so a warm restart resumes them;
  // cold-start retention needs non-volatile backing outside this block.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q.wst <= ax_idle;
      q.aw_got <= 1'b0;
      q.w_got <= 1'b0;
      q.awaddr <= 12'h000;
      q.wdata <= 32'h00000000;
      q.wstrb <= 4'h0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.bvalid <= 1'b0;
      q.bresp <= 2'b00;
      q.arready <= 1'b0;
      q.rvalid <= 1'b0;
      q.rdata <= 32'h00000000;
      q.rresp <= 2'b00;
      q.gen_cfg <= 32'h00000000;
      q.di_inv <= 8'h00;
      q.deb_ms <= 16'h0000;
      q.boot_div <= `BOOT_DIV_RST;
      q.di_deb <= '0;
      q.di_cnt <= '0;
      q.di_out <= '0;
      q.o_hold <= '0;
      q.o_toff <= '0;
      q.cmd <= 4'h0;
      q.boot_cnt <= 32'h00000000;
      q.health <= 1'b0;
      q.ocfg <= d.ocfg;
      q.lcfg <= d.lcfg;
      q.o_latch <= d.o_latch; // R12
      q.l_latch <= d.l_latch; // R12
      q.o_state <= d.o_state; // R12
      q.relay <= d.relay;
      q.led <= d.led;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign relay_drive = q.relay;
  assign led_on = q.led;
  assign di_state = q.di_out;
  assign health_led = q.health;
endmodule // binary_io_latch_ack_logic

// >>> hw/bio_defs.svh
// Offsets, field positions, reset values and timing counts of the binary I/O block
`ifndef BIO_DEFS_SVH
`define BIO_DEFS_SVH
`define N_OUT 4
`define N_LED 4
`define N_DI 8
`define N_SLOT 7
`define N_SIG 32
`define CLK_HZ 25000000
// Register byte offsets
`define A_GLOBAL 12'h000
`define A_STATUS 12'h004
`define A_DI_INV 12'h008
`define A_DEB 12'h00C
`define A_BOOT_DIV 12'h010
`define A_OUT_BASE 12'h100
`define A_LED_BASE 12'h180
// Per-output 8 words: 0..6 slot cfg, 7 mode; per-LED 8 words: 0..6 slot cfg (5 used), 7 mode
// Slot cfg fields
`define F_SEL_LO 0
`define F_SEL_HI 4
`define F_ASSIGNED 8
`define F_SLOT_INV 9
// Output mode word fields
`define F_COLL_INV 0
`define F_CLOSED 1
`define F_LATCH 2
`define F_ACK_SEL_LO 8
`define F_ACK_SEL_HI 12
`define F_ACK_EN 13
`define F_TOFF_LO 16
`define F_TOFF_HI 23
`define F_THOLD_LO 24
`define F_THOLD_HI 31
// LED mode word fields
`define F_LED_LATCH 2
`define F_LED_BY_ALARM 3
// Global word fields
`define F_REMOTE_RESET 0
`define F_BOOT_DONE 1
// Command pulses written to the global word
`define F_CMD_PANEL_OUT 8
`define F_CMD_SCADA_OUT 9
`define F_CMD_PANEL_LED 10
`define F_CMD_SCADA_LED 11
// Timer units: times are programmed in ms, one ms is this many clocks
`define MS_NS 1000000
`define CLK_NS 40
`define MS_CYC (`MS_NS / `CLK_NS)
`define BOOT_DIV_RST 32'h00300000
`endif

// >>> hw/bio_pkg.sv
// Types of the binary I/O block
package bio_pkg;
  typedef enum logic [1:0] {ax_idle, ax_resp} axs_t;
endpackage

// >>> sim/bio_asserts.sv
// Bus handshake checker for the binary I/O block
`timescale 1ns/1ps
module bio_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[2:3] s_axi_bvalid) else $error("write answer late");
  ar_single_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
    else $error("second read taken");
  rresp_code_a: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'b00, 2'b10})
    else $error("bad read response code");
  aw_closed_a: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready))
    else $error("address open before response");
endmodule // bio_asserts
bind binary_io_latch_ack_logic bio_asserts chk_i (.*);

// >>> sim/prot_sig_src.sv
// Model of protection signals and acknowledge sources feeding the block
`timescale 1ns/1ps
module prot_sig_src (
  input wire logic aclk,
  input wire logic [34:0] cmd,
  output logic [31:0] trig_in,
  output logic all_output_clear_source,
  output logic all_indicator_clear_source,
  output logic prot_alarm
);
  // Sources change just after an edge, one cycle behind the request
  initial {prot_alarm, all_indicator_clear_source, all_output_clear_source, trig_in} = '0;
  always @(posedge aclk) begin
    {prot_alarm, all_indicator_clear_source, all_output_clear_source, trig_in} <= cmd;
  end
endmodule // prot_sig_src

// >>> sim/tb.sv
// Self-checking bench for the binary I/O block
`timescale 1ns/1ps
`include "bio_defs.svh"
module tb;
  logic aclk, aresetn, health_led;
  logic [`N_DI-1:0] di_raw, di_state;
  logic [`N_SIG-1:0] trig_in;
  logic all_output_clear_source, all_indicator_clear_source, prot_alarm;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [`N_OUT-1:0] relay_drive;
  logic [`N_LED-1:0] led_on;
  logic [34:0] cmd;
  int error_cnt, num_checks, ones;
  binary_io_latch_ack_logic uut (.*);
  prot_sig_src src (.*);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cr(input logic [3:0] e);
    tick(4);
    chk("relay_drive", 32'(e), 32'(relay_drive));
  endtask
  task automatic cl(input logic [3:0] e);
    tick(4);
    chk("led_on", 32'(e), 32'(led_on));
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic pulse(input logic [34:0] v);
    cmd <= v;
    tick(4);
    cmd <= '0;
    tick(6);
  endtask
  task automatic count_ones;
    ones = 0;
    repeat (130) begin
      @(posedge aclk);
      if (health_led === 1'b1) ones++;
    end
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Three one-millisecond waits dominate the run
  initial begin
    repeat (90000) @(posedge aclk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, di_raw, cmd} = '0;
    s_axi_wstrb = 4'hF;
    tick(10);
    aresetn <= 1'b1;
    // Short flash period set before the boot counter passes it
    wr(12'h010, 32'h0000_0040);
    tick(70);
    count_ones();
    chk("health_flash", 32'd65, 32'(ones));
    // Tables are not cleared by reset, so every word is written first
    for (int i = 0; i < 64; i++) wr(12'(256 + 4 * i), 32'h0);
    wr(12'h100, 32'h0000_0103);
    wr(12'h104, 32'h0000_0200);
    cmd <= 35'h8;
    cr(4'h1);
    cmd <= '0;
    cr(4'h0);
    wr(12'h104, 32'h0000_0301);
    cr(4'h1);
    wr(12'h104, 32'h0);
    wr(12'h11C, 32'h1);
    cr(4'h1);
    wr(12'h100, 32'h0);
    cr(4'h0);
    wr(12'h11C, 32'h2);
    cr(4'h1);
    wr(12'h100, 32'h0000_0103);
    wr(12'h11C, 32'h0000_2504);
    pulse(35'h8);
    cr(4'h1);
    pulse(35'h28);
    cr(4'h1);
    pulse(35'h20);
    cr(4'h0);
    pulse(35'h8);
    pulse(35'h1_0000_0000);
    cr(4'h1);
    wr(12'h000, 32'h1);
    pulse(35'h1_0000_0000);
    cr(4'h0);
    pulse(35'h8);
    wr(12'h000, 32'h201);
    cr(4'h0);
    pulse(35'h8);
    wr(12'h000, 32'h100);
    cr(4'h0);
    pulse(35'h8);
    aresetn <= 1'b0;
    tick(3);
    aresetn <= 1'b1;
    cr(4'h1);
    wr(12'h11C, 32'h0);
    cr(4'h0);
    wr(12'h11C, 32'h0001_2504);
    pulse(35'h8);
    cmd <= 35'h20;
    tick(100);
    cr(4'h1);
    tick(25000);
    cr(4'h0);
    cmd <= '0;
    wr(12'h11C, 32'h0100_0000);
    pulse(35'h8);
    tick(100);
    cr(4'h1);
    tick(25000);
    cr(4'h0);
    wr(12'h00C, 32'h1);
    di_raw <= 8'h01;
    tick(4);
    chk("di_state", 32'h1, 32'(di_state));
    di_raw <= 8'h00;
    tick(4);
    chk("di_state", 32'h1, 32'(di_state));
    tick(25100);
    chk("di_state", 32'h0, 32'(di_state));
    wr(12'h008, 32'hFF);
    tick(4);
    chk("di_state", 32'hFF, 32'(di_state));
    wr(12'h180, 32'h0000_0104);
    wr(12'h19C, 32'h0000_000C);
    pulse(35'h10);
    cl(4'h1);
    pulse(35'h4_0000_0000);
    cl(4'h0);
    wr(12'h19C, 32'h4);
    pulse(35'h10);
    pulse(35'h4_0000_0000);
    cl(4'h1);
    pulse(35'h2_0000_0000);
    cl(4'h1);
    cmd <= 35'h10;
    tick(4);
    wr(12'h000, 32'h400);
    cmd <= '0;
    cl(4'h1);
    wr(12'h000, 32'h801);
    cl(4'h0);
    pulse(35'h10);
    cl(4'h1);
    wr(12'h000, 32'h400);
    cl(4'h0);
    wr(12'hFFC, 32'h0);
    chk("bresp", 32'h2, 32'(rsp));
    rd(12'hFFC);
    chk("rresp", 32'h2, 32'(rsp));
    chk("rdata_unmapped", 32'h0, rd_data);
    rd(12'h19C);
    chk("led_mode", 32'h4, rd_data);
    wr(12'h000, 32'h2);
    tick(2);
    count_ones();
    chk("health_steady", 32'd130, 32'(ones));
    report_and_stop();
  end
endmodule // tb
